// ==== dper_map.svh ====
// Register map, field positions, reset values and timing counts
`ifndef DPER_MAP_SVH
`define DPER_MAP_SVH

// ---------------------------------------------------------------
// Register indices (byte address is four times the index)
// ---------------------------------------------------------------
`define DPER_IDX_ERR 10'h010
`define DPER_IDX_RST 10'h014
`define DPER_IDX_PRES 10'h016
`define DPER_IDX_IRQ_STAT 10'h020
`define DPER_IDX_IRQ_MASK 10'h021
`define DPER_IDX_CTRL 10'h022

// ---------------------------------------------------------------
// Fields and reset values
// ---------------------------------------------------------------
`define DPER_PORTS 4
`define DPER_ERR_RESET 4'h0
`define DPER_RST_RESET 4'hF
`define DPER_PRES_RESET 4'h0
`define DPER_IRQ_PRES_BIT 4
`define DPER_CTRL_ERRMASK_BIT 0
`define DPER_BE_LEGAL_HI 4'hC
`define DPER_BE_LEGAL_LO 4'h3
`define DPER_BE_LEGAL_NONE 4'h0

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define DPER_RDY_TIMEOUT_CLKS 16

`endif

// ==== dper_pkg.sv ====
// Types shared by the DSP port error and reset register block
package dper_pkg;

    typedef struct packed {
        logic valid;
        logic [1:0] port;
        logic [3:0] be;
    } dper_txn_t;

    typedef struct packed {
        logic valid;
        logic [3:0] bits;
    } dper_rom_t;

    typedef enum logic [0:0] {
        DPER_IDLE,
        DPER_DONE
    } dper_phase_t;

    typedef struct packed {
        logic [7:0] cnt;
        logic fired;
        logic timeout;
    } dper_watch_t;

    typedef struct packed {
        logic [3:0] rdyn_a;
        logic [3:0] rdyn_b;
        logic [3:0] rdyw_a;
        logic [3:0] rdyw_b;
        logic brst_a;
        logic brst_b;
        dper_phase_t phase;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic [3:0] err;
        logic [3:0] rst_ctl;
        logic [3:0] rst_n_out;
        logic [3:0] presence;
        logic [4:0] irq_stat;
        logic [4:0] irq_mask;
        logic err_mask;
        logic evt_flag;
        logic irq;
        logic abort;
    } dper_state_t;

endpackage

// ==== dper_ready_watch.sv ====
// Ready timeout watcher for one DSP host port
`timescale 1ns/100ps
`include "dper_map.svh"

module dper_ready_watch #(
    parameter int TIMEOUT = `DPER_RDY_TIMEOUT_CLKS
) (
    input wire logic clock_i,
    input wire logic rstn_i,
    input wire logic cs_i,
    input wire logic rdy_i,
    output logic timeout_o
);

    dper_pkg::dper_watch_t s;
    dper_pkg::dper_watch_t next_s;

    // ---------------------------------------------------------------
    // Counter
    // ---------------------------------------------------------------
    // Fires once per chip select; ready seen ends the watch
    always_comb begin
        next_s = s;
        next_s.timeout = 1'b0;
        if (!cs_i) begin
            next_s.cnt = 8'h00;
            next_s.fired = 1'b0;
        end else if (rdy_i) begin
            next_s.fired = 1'b1;
        end else if (!s.fired) begin
            next_s.cnt = s.cnt + 8'h01;
            if (s.cnt == 8'(TIMEOUT - 1)) begin
                next_s.timeout = 1'b1;
                next_s.fired = 1'b1;
            end
        end
    end

    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign timeout_o = s.timeout;

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    a_timeout_at_count: assert property (@(posedge clock_i) disable iff (!rstn_i)
        (cs_i && !rdy_i && !s.fired && s.cnt == 8'(TIMEOUT - 1)) |=> timeout_o)
        else $error("ready timeout missed");

    a_timeout_cause: assert property (@(posedge clock_i) disable iff (!rstn_i)
        timeout_o |-> ($past(cs_i) && !$past(rdy_i)) ##1 !timeout_o)
        else $error("ready timeout without cause");

endmodule

// ==== dper_regs.sv ====
// DSP host port error, reset control and presence registers on APB
`timescale 1ns/100ps
`include "dper_map.svh"

// How it works
// - Any error bit raises port error event flag
// - Software write may set error bits
// - Unused upper register bits read zero
// - Error bit x belongs to port x
// - No ready within 16 clocks flags error
// - Read discard timeout flags that port
// - Illegal byte enables on narrow port flag
// - Reset bit one drives DSP reset out
// - Reset bits default to ones, 000Fh
// - Reset bits survive bus reset, global only
// - Presence bits load from serial ROM
// - Presence resets to zero before loading
// - Error mask blocks aborts and system errors

module dper_regs #(
    parameter int PORTS = `DPER_PORTS,
    parameter int RDY_TIMEOUT = `DPER_RDY_TIMEOUT_CLKS
) (
    input wire logic clock_i,
    input wire logic rstn_i,
    input wire logic bus_rstn_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [3:0] pstrb_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic [3:0] port_chip_select_i,
    input wire logic [3:0] narrow_port_ready_n_i,
    input wire logic [3:0] wide_port_ready_n_i,
    input wire logic [3:0] port_wide_i,
    input wire logic [3:0] discard_expire_i,
    input dper_pkg::dper_txn_t txn_i,
    input dper_pkg::dper_rom_t rom_i,
    output logic [3:0] port_error_bits_o,
    output logic port_error_event_flag_o,
    output logic [3:0] dsp_reset_out_n_o,
    output logic [3:0] dsp_present_o,
    output logic target_abort_o,
    output logic serr_block_o,
    output logic irq_o
);

    dper_pkg::dper_state_t s;
    dper_pkg::dper_state_t next_s;
    logic [3:0] rdy_hi;
    logic [3:0] timeout;
    logic [3:0] be_err;
    logic [3:0] hw_set;
    logic access;
    logic commit;
    logic wr_low;
    logic [9:0] idx;
    logic mapped;
    logic [31:0] rd_val;

    // ---------------------------------------------------------------
    // Per-port ready timeout
    // ---------------------------------------------------------------
    // Ready is seen two clocks late through the synchroniser
    genvar g;
    generate
        for (g = 0; g < PORTS; g++) begin : g_port
            assign rdy_hi[g] = port_wide_i[g] ? ~s.rdyw_b[g] : ~s.rdyn_b[g];
            // Two extra counts cover the synchroniser delay on ready
            dper_ready_watch #(
                .TIMEOUT(RDY_TIMEOUT + 2)
            ) u_watch (
                .clock_i(clock_i),
                .rstn_i(rstn_i),
                .cs_i(port_chip_select_i[g]),
                .rdy_i(rdy_hi[g]),
                .timeout_o(timeout[g])
            );
            assign be_err[g] = txn_i.valid && (txn_i.port == 2'(g)) && !port_wide_i[g]
                && (txn_i.be != `DPER_BE_LEGAL_HI) && (txn_i.be != `DPER_BE_LEGAL_LO)
                && (txn_i.be != `DPER_BE_LEGAL_NONE);
        end
    endgenerate

    assign hw_set = timeout | discard_expire_i | be_err;

    // ---------------------------------------------------------------
    // APB decode
    // ---------------------------------------------------------------
    assign access = psel_i && penable_i;
    assign commit = access && s.pready;
    assign wr_low = commit && pwrite_i && pstrb_i[0];
    assign idx = paddr_i[11:2];

    always_comb begin
        mapped = 1'b1;
        rd_val = 32'h0000_0000;
        case (idx)
            `DPER_IDX_ERR: rd_val = {28'h000_0000, s.err};
            `DPER_IDX_RST: rd_val = {28'h000_0000, s.rst_ctl};
            `DPER_IDX_PRES: rd_val = {28'h000_0000, s.presence};
            `DPER_IDX_IRQ_STAT: rd_val = {27'h000_0000, s.irq_stat};
            `DPER_IDX_IRQ_MASK: rd_val = {27'h000_0000, s.irq_mask};
            `DPER_IDX_CTRL: rd_val = {31'h0000_0000, s.err_mask};
            default: mapped = 1'b0;
        endcase
    end

    // ---------------------------------------------------------------
    // Next state
    // ---------------------------------------------------------------
    always_comb begin
        next_s = s;
        next_s.rdyn_a = narrow_port_ready_n_i;
        next_s.rdyn_b = s.rdyn_a;
        next_s.rdyw_a = wide_port_ready_n_i;
        next_s.rdyw_b = s.rdyw_a;
        next_s.brst_a = bus_rstn_i;
        next_s.brst_b = s.brst_a;

        // One wait state: answer one clock after the access phase opens
        case (s.phase)
            dper_pkg::DPER_IDLE: begin
                next_s.pready = 1'b0;
                if (access) begin
                    next_s.pready = 1'b1;
                    next_s.pslverr = !mapped;
                    next_s.prdata = pwrite_i ? 32'h0000_0000 : rd_val;
                    next_s.phase = dper_pkg::DPER_DONE;
                end
            end
            dper_pkg::DPER_DONE: begin
                next_s.pready = 1'b0;
                next_s.pslverr = 1'b0;
                next_s.prdata = 32'h0000_0000;
                next_s.phase = dper_pkg::DPER_IDLE;
            end
            default: begin
                next_s.pready = 1'b0;
                next_s.phase = dper_pkg::DPER_IDLE;
            end
        endcase

        // Bus reset clears error context only; reset control is untouched
        if (!s.brst_b) begin
            next_s.err = `DPER_ERR_RESET;
            next_s.irq_stat = 5'h00;
            next_s.irq_mask = 5'h00;
            next_s.err_mask = 1'b0;
        end else if (wr_low) begin
            case (idx)
                `DPER_IDX_ERR: next_s.err = pwdata_i[3:0];
                `DPER_IDX_IRQ_MASK: next_s.irq_mask = pwdata_i[4:0];
                `DPER_IDX_CTRL: next_s.err_mask = pwdata_i[`DPER_CTRL_ERRMASK_BIT];
                default: next_s.err = s.err;
            endcase
        end
        if (wr_low && idx == `DPER_IDX_RST) begin
            next_s.rst_ctl = pwdata_i[3:0];
        end
        // Clear only what the read returned; later events stay pending
        if (commit && !pwrite_i && idx == `DPER_IDX_IRQ_STAT) begin
            next_s.irq_stat = next_s.irq_stat & ~s.prdata[4:0];
        end

        // Hardware only sets; a same-cycle clear loses
        next_s.err = next_s.err | hw_set;
        next_s.irq_stat[3:0] = next_s.irq_stat[3:0] | hw_set;

        if (wr_low && idx == `DPER_IDX_PRES) begin
            next_s.presence = pwdata_i[3:0];
        end
        if (rom_i.valid) begin
            next_s.presence = rom_i.bits;
            next_s.irq_stat[`DPER_IRQ_PRES_BIT] = 1'b1;
        end

        next_s.rst_n_out = ~next_s.rst_ctl;
        next_s.evt_flag = |next_s.err;
        next_s.irq = |(next_s.irq_stat & next_s.irq_mask);
        next_s.abort = (|hw_set) && !s.err_mask;
    end

    // ---------------------------------------------------------------
    // State register
    // ---------------------------------------------------------------
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            s <= '0;
            s.rdyn_a <= 4'hF;
            s.rdyn_b <= 4'hF;
            s.rdyw_a <= 4'hF;
            s.rdyw_b <= 4'hF;
            s.phase <= dper_pkg::DPER_IDLE;
            s.err <= `DPER_ERR_RESET;
            s.rst_ctl <= `DPER_RST_RESET;
            s.rst_n_out <= ~`DPER_RST_RESET;
            s.presence <= `DPER_PRES_RESET;
        end else begin
            s <= next_s;
        end
    end

    // ---------------------------------------------------------------
    // Outputs
    // ---------------------------------------------------------------
    assign prdata_o = s.prdata;
    assign pready_o = s.pready;
    assign pslverr_o = s.pslverr;
    assign port_error_bits_o = s.err;
    assign port_error_event_flag_o = s.evt_flag;
    assign dsp_reset_out_n_o = s.rst_n_out;
    assign dsp_present_o = s.presence;
    assign target_abort_o = s.abort;
    assign serr_block_o = s.err_mask;
    assign irq_o = s.irq;

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!rstn_i);

    sequence s_err_write;
        wr_low && idx == `DPER_IDX_ERR && s.brst_b;
    endsequence

    sequence s_rst_write;
        wr_low && idx == `DPER_IDX_RST;
    endsequence

    a_flag_on_error: assert property (
        (|hw_set) |=> port_error_event_flag_o && target_abort_o == !$past(s.err_mask))
        else $error("error did not raise event flag");

    a_sw_set_error: assert property (
        (s_err_write and (pwdata_i[3:0] != 4'h0)) |=> port_error_event_flag_o
            && ((port_error_bits_o & $past(pwdata_i[3:0])) == $past(pwdata_i[3:0])))
        else $error("software error set lost");

    a_upper_zero: assert property (
        (pready_o && !pslverr_o) |-> prdata_o[31:5] == 27'h000_0000)
        else $error("upper read bits not zero");

    a_err_sticky: assert property (
        ((port_error_bits_o & ~$past(port_error_bits_o)) == 4'h0 && $fell(|port_error_bits_o))
            |-> $past(wr_low && idx == `DPER_IDX_ERR) || !$past(s.brst_b))
        else $error("error bit cleared without write");

    a_discard_sets: assert property (
        (|discard_expire_i) |=> (port_error_bits_o & $past(discard_expire_i))
            == $past(discard_expire_i))
        else $error("discard timeout not recorded");

    a_be_illegal: assert property (
        (txn_i.valid && !port_wide_i[txn_i.port] && txn_i.be == 4'hF)
            |=> port_error_bits_o[$past(txn_i.port)])
        else $error("illegal byte enables not flagged");

    a_reset_follows: assert property (
        s_rst_write |=> dsp_reset_out_n_o == ~$past(pwdata_i[3:0]) ##1
            (dsp_reset_out_n_o == ~s.rst_ctl))
        else $error("dsp reset output does not follow control");

    a_bus_reset_keeps: assert property (
        (!s.brst_b && !(wr_low && idx == `DPER_IDX_RST)) |=> $stable(dsp_reset_out_n_o))
        else $error("bus reset disturbed dsp reset");

    a_presence_load: assert property (
        rom_i.valid |=> dsp_present_o == $past(rom_i.bits) && irq_stat_pres_set())
        else $error("presence not loaded from rom");

    a_abort_masked: assert property (
        target_abort_o |-> !$past(s.err_mask) && $past(|hw_set))
        else $error("abort while error mask set");

    a_answer_time: assert property (
        (access && !s.pready && s.phase == dper_pkg::DPER_IDLE) |=> pready_o ##1 !pready_o)
        else $error("apb answer not after one wait");

    a_timeout_sets: assert property (
        (|timeout) |=> (port_error_bits_o & $past(timeout)) == $past(timeout))
        else $error("ready timeout not recorded");

    a_reg_upper_zero: assert property (
        (access && s.pready && (idx == `DPER_IDX_ERR || idx == `DPER_IDX_RST
            || idx == `DPER_IDX_PRES)) |-> prdata_o[31:4] == 28'h000_0000)
        else $error("register upper bits not zero");

    a_flag_clears: assert property (
        (port_error_bits_o == 4'h0) |-> !port_error_event_flag_o)
        else $error("event flag without error");

    a_stat_keeps_event: assert property (
        (commit && !pwrite_i && idx == `DPER_IDX_IRQ_STAT && (|hw_set))
            |=> (s.irq_stat[3:0] & $past(hw_set)) == $past(hw_set))
        else $error("event lost in status read");

    function automatic logic irq_stat_pres_set();
        irq_stat_pres_set = s.irq_stat[`DPER_IRQ_PRES_BIT];
    endfunction

endmodule

// ==== dper_dsp_model.sv ====
// Behavioural model of four DSP host ports answering chip select with ready
`timescale 1ns/100ps

module dper_dsp_model (
    input wire logic clock_i,
    input wire logic [3:0] cs_i,
    input wire logic [3:0] wide_i,
    input wire logic [3:0] dsp_rstn_i,
    input wire logic [31:0] delay_i,
    output logic [3:0] narrow_rdy_n_o,
    output logic [3:0] wide_rdy_n_o
);
    logic [7:0] cnt [4] = '{default: 8'h00};
    logic [3:0] rdy = 4'h0;

    // ---------------------------------------------------------------
    // Ready after a per-port delay; 8'hFF never answers in practice
    // ---------------------------------------------------------------
    always @(posedge clock_i) begin
        for (int p = 0; p < 4; p++) begin
            // A DSP held in reset stays silent
            if (!cs_i[p] || !dsp_rstn_i[p]) begin
                cnt[p] <= 8'h00;
                rdy[p] <= 1'b0;
            end else if (cnt[p] == delay_i[p*8 +: 8]) begin
                rdy[p] <= 1'b1;
            end else begin
                cnt[p] <= cnt[p] + 8'h01;
            end
        end
    end

    // Released lines sit at the pull-up level
    always_comb begin
        narrow_rdy_n_o = ~(rdy & ~wide_i);
        wide_rdy_n_o = ~(rdy & wide_i);
    end
endmodule

// ==== dper_regs_test.sv ====
// Self-checking bench for the DSP port error, reset and presence registers
`timescale 1ns/100ps
`include "dper_map.svh"

module dper_regs_test;
    // Short timeout keeps the run brief
    localparam int TO = 8;
    localparam logic [11:0] A_ERR = {`DPER_IDX_ERR, 2'b00};
    localparam logic [11:0] A_RST = {`DPER_IDX_RST, 2'b00};
    localparam logic [11:0] A_PRES = {`DPER_IDX_PRES, 2'b00};
    localparam logic [11:0] A_STAT = {`DPER_IDX_IRQ_STAT, 2'b00};
    localparam logic [11:0] A_MASK = {`DPER_IDX_IRQ_MASK, 2'b00};
    localparam logic [11:0] A_CTRL = {`DPER_IDX_CTRL, 2'b00};
    logic clock_i = 1'b0;
    logic rstn_i = 1'b0;
    logic bus_rstn_i = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, se;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd, expv;
    logic [31:0] delay = 32'h0600_00FF;
    logic [3:0] cs = 4'h0, wide = 4'h4, disc = 4'h0, nrdy_n, wrdy_n;
    logic [3:0] err_bits, rst_n, pres;
    logic evt, abort, serr_blk, irq;
    dper_pkg::dper_txn_t txn = '0;
    dper_pkg::dper_rom_t rom = '0;
    int num_errors = 0, n_tests = 0, cycles = 0, n_abort = 0, n0;

    dper_regs #(.RDY_TIMEOUT(TO)) dper_regs_i (
        .clock_i(clock_i), .rstn_i(rstn_i), .bus_rstn_i(bus_rstn_i),
        .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
        .pwdata_i(pwdata), .pstrb_i(4'hF), .prdata_o(prdata), .pready_o(pready),
        .pslverr_o(pslverr), .port_chip_select_i(cs), .narrow_port_ready_n_i(nrdy_n),
        .wide_port_ready_n_i(wrdy_n), .port_wide_i(wide), .discard_expire_i(disc),
        .txn_i(txn), .rom_i(rom), .port_error_bits_o(err_bits),
        .port_error_event_flag_o(evt), .dsp_reset_out_n_o(rst_n), .dsp_present_o(pres),
        .target_abort_o(abort), .serr_block_o(serr_blk), .irq_o(irq));

    dper_dsp_model dper_dsp_model_i (
        .clock_i(clock_i), .cs_i(cs), .wide_i(wide), .dsp_rstn_i(rst_n),
        .delay_i(delay), .narrow_rdy_n_o(nrdy_n), .wide_rdy_n_o(wrdy_n));

    // ---------------------------------------------------------------
    // Clock, abort pulse count and hang guard
    // ---------------------------------------------------------------
    always #50 clock_i = ~clock_i;

    always @(posedge clock_i) begin
        cycles++;
        if (abort === 1'b1) n_abort++;
        if (cycles == 5000) begin
            num_errors++;
            conclude();
        end
    end

    // ---------------------------------------------------------------
    // Tasks
    // ---------------------------------------------------------------
    task automatic conclude();
        if (num_errors == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clock_i);
    endtask

    // Request held until pready is seen at an edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int w;
        w = 0;
        @(posedge clock_i);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clock_i);
        penable <= 1'b1;
        do begin
            @(posedge clock_i);
            w++;
        end while (pready !== 1'b1 && w < 50);
        if (pready !== 1'b1) num_errors++;
        rd = prdata;
        se = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask

    task automatic pulse(input logic [3:0] d, input logic [6:0] t, input logic [4:0] r);
        @(posedge clock_i);
        disc <= d;
        txn <= t;
        rom <= r;
        @(posedge clock_i);
        disc <= 4'h0;
        txn <= '0;
        rom <= '0;
        tick(2);
    endtask

    // ---------------------------------------------------------------
    // Main sequence
    // ---------------------------------------------------------------
    initial begin
        tick(2);
        rstn_i <= 1'b1;
        rchk(A_ERR, 32'h0);
        rchk(A_RST, 32'h0000_000F);
        chk({28'h0, rst_n}, 32'h0);
        rchk(A_PRES, 32'h0);
        apb(1'b1, A_RST, 32'hFFFF_FFF5);
        rchk(A_RST, 32'h5);
        chk({28'h0, rst_n}, 32'hA);
        apb(1'b1, A_ERR, 32'hFFFF_FFF6);
        tick(2);
        chk({28'h0, err_bits}, 32'h6);
        chk({31'h0, evt}, 32'h1);
        rchk(A_ERR, 32'h6);
        // Bus reset drops errors but not the power-managed reset bits
        bus_rstn_i <= 1'b0;
        tick(4);
        bus_rstn_i <= 1'b1;
        tick(4);
        rchk(A_ERR, 32'h0);
        rchk(A_RST, 32'h5);
        chk({31'h0, evt}, 32'h0);
        apb(1'b1, A_RST, 32'h0);
        for (int p = 0; p < 4; p++) begin
            pulse(4'h1 << p, 7'h0, 5'h0);
            tick(8);
            rchk(A_ERR, 32'h1 << p);
            chk({31'h0, evt}, 32'h1);
            apb(1'b1, A_ERR, 32'h0);
        end
        chk(n_abort, 32'd4);
        // Port 1 narrow, port 2 wide: only narrow ports check lanes
        for (int b = 0; b < 16; b++) begin
            pulse(4'h0, {1'b1, 2'd1, b[3:0]}, 5'h0);
            pulse(4'h0, {1'b1, 2'd2, b[3:0]}, 5'h0);
            expv = (b[3:0] == `DPER_BE_LEGAL_HI || b[3:0] == `DPER_BE_LEGAL_LO ||
                b[3:0] == `DPER_BE_LEGAL_NONE) ? 32'h0 : 32'h2;
            rchk(A_ERR, expv);
            apb(1'b1, A_ERR, 32'h0);
        end
        // Port 0 silent, port 2 at once, port 3 ready on the last allowed clock
        @(posedge clock_i);
        cs <= 4'hD;
        tick(TO + 3);
        chk({28'h0, err_bits}, 32'h0);
        tick(1);
        chk({28'h0, err_bits}, 32'h1);
        cs <= 4'h0;
        apb(1'b0, A_STAT, 32'h0);
        apb(1'b1, A_MASK, 32'h10);
        pulse(4'h8, 7'h0, 5'h0);
        chk({31'h0, irq}, 32'h0);
        pulse(4'h0, 7'h0, 5'h1B);
        rchk(A_PRES, 32'hB);
        chk({28'h0, pres}, 32'hB);
        chk({31'h0, irq}, 32'h1);
        rchk(A_STAT, 32'h18);
        tick(2);
        chk({31'h0, irq}, 32'h0);
        // Masked errors raise no abort
        apb(1'b1, A_CTRL, 32'h1);
        tick(2);
        chk({31'h0, serr_blk}, 32'h1);
        n0 = n_abort;
        pulse(4'h2, 7'h0, 5'h0);
        tick(2);
        chk(n_abort, n0);
        apb(1'b0, 12'hFFC, 32'h0);
        chk({31'h0, se}, 32'h1);
        rstn_i <= 1'b0;
        tick(2);
        rstn_i <= 1'b1;
        rchk(A_RST, 32'hF);
        rchk(A_PRES, 32'h0);
        conclude();
    end
endmodule
